// ===== verilog/fls_pkg.sv
// constants, types and helpers shared by the field limit switch block
package fls_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int INT_PULSE_NS = 10000;
	localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CNT_W = 8;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DATA_W = 12;
	localparam int VAL_W = 13;
	localparam int ANG_W = 9;

	// ----------------------------------------
	// register indexes
	// ----------------------------------------
	localparam logic [3:0] ADDR_LIMIT_WORD_ONE = 4'h0;
	localparam logic [3:0] ADDR_LIMIT_WORD_TWO = 4'h1;
	localparam logic [3:0] ADDR_LIMIT_WORD_THREE = 4'h2;
	localparam logic [3:0] ADDR_X_UPPER_LIMIT = 4'h3;
	localparam logic [3:0] ADDR_Y_UPPER_LIMIT = 4'h4;
	localparam logic [3:0] ADDR_Z_UPPER_LIMIT = 4'h5;
	localparam logic [3:0] ADDR_LIMIT_CTRL = 4'h6;
	localparam logic [3:0] ADDR_SWITCH_HYST = 4'h7;
	localparam logic [3:0] ADDR_MAGNITUDE_RESULT = 4'h8;
	localparam logic [3:0] ADDR_LIMIT_STATUS = 4'h9;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_DIR_BIT = 2;
	localparam int CTRL_MODE_LSB = 3;
	localparam int HYST_LSB = 0;
	localparam int STAT_SWITCH_BIT = 7;
	localparam int STAT_ANGLE_BIT = 4;
	localparam int STAT_MAG_BIT = 3;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_LIMIT = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [2:0] RST_HYST = 3'h0;
	localparam logic [7:0] RST_RESULT = 8'h00;

	// ----------------------------------------
	// angle scaling
	// ----------------------------------------
	localparam logic [9:0] ANGLE_FULL_DEG = 10'h168;
	localparam int ANGLE_REF_SHIFT = 1;

	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		SEL_OFF = 2'b00,
		SEL_ANGLE = 2'b01,
		SEL_AXIS = 2'b10,
		SEL_MAG = 2'b11
	} fls_sel_e;

	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_UNIPOLAR = 3'h5;
	localparam logic [2:0] MODE_OMNIPOLAR = 3'h6;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EVAL = 1'b1
	} fls_stage_e;

	function automatic logic signed [VAL_W-1:0] fls_abs(input logic signed [VAL_W-1:0] v);
		fls_abs = v[VAL_W-1] ? -v : v;
	endfunction

	function automatic logic [9:0] fls_wrap360(input logic [9:0] v);
		fls_wrap360 = (v >= ANGLE_FULL_DEG) ? v - ANGLE_FULL_DEG : v;
	endfunction

endpackage

// ===== verilog/fls_cmp_if.sv
// carrier between the top and one limit comparator
`timescale 1ns/1ps
interface fls_cmp_if;
	import fls_pkg::*;
	logic signed [VAL_W-1:0] value;
	logic signed [VAL_W-1:0] lo;
	logic signed [VAL_W-1:0] hi;
	logic signed [VAL_W-1:0] hyst;
	logic loEn;
	logic hiEn;
	logic dir;
	logic omni;
	logic oor;
	logic opHit;
	logic hiHit;
	logic rpBelow;
	modport drv (output value, lo, hi, hyst, loEn, hiEn, dir, omni, input oor, opHit, hiHit, rpBelow);
	modport cmp (input value, lo, hi, hyst, loEn, hiEn, dir, omni, output oor, opHit, hiHit, rpBelow);
endinterface

// ===== verilog/fls_limit_cmp.sv
// one channel compared against its low and high limits
`timescale 1ns/1ps
module fls_limit_cmp (
	fls_cmp_if.cmp c
);
	import fls_pkg::*;

	logic signed [VAL_W-1:0] v;
	logic signed [VAL_W-1:0] l;
	logic signed [VAL_W-1:0] h;
	logic signed [VAL_W-1:0] rel;

	// omnipolar drops the sign of field and limits
	always_comb begin
		v = c.omni ? fls_abs(c.value) : c.value;
		l = c.omni ? fls_abs(c.lo) : c.lo;
		h = c.omni ? fls_abs(c.hi) : c.hi;
		rel = l - c.hyst;
	end

	// region decision; a zero limit takes no part
	always_comb begin
		if (!c.dir) begin
			c.oor = (c.hiEn && (v > h)) || (c.loEn && (v < l));
		end else begin
			c.oor = (c.loEn || c.hiEn) && (!c.loEn || (v >= l)) && (!c.hiEn || (v <= h));
		end
		c.opHit = c.loEn && (v >= l);
		c.hiHit = c.hiEn && (v >= h);
		c.rpBelow = !c.loEn || (v < rel);
	end

endmodule

// ===== verilog/fls_field_limit_switch.sv
// threshold checks and interrupt / switch pin of the field sensor
//
// Function
// - re-interrupt every conversion while out of range
// - direction bit picks outside or inside regions
// - axis checks in every operating mode
// - selector 3h compares magnitude
// - magnitude result stored and compared
// - magnitude: word one low, two high, unsigned
// - limits independent; zero limit skipped
// - magnitude checks in every operating mode
// - selector 1h: angle reference and band
// - reference is 2 degrees per step
// - band is 1 degree per step
// - word three offsets the computed angle
// - switch mode drives a held level
// - switch mode in every power mode
// - no pin trigger while switch mode
// - unipolar: on above operate, off below release
// - selector 2h gives three-axis switch
// - any enabled channel over its low word turns on
// - hysteresis field sets release below operate
// - off only when all enabled channels released
// - omnipolar uses both polarities alike
// - axis limits signed, 128 is full scale
// - axis upper limits from separate words
// - pin mode 5h enters switch behaviour
// - omnipolar ignores threshold sign bits
`timescale 1ns/1ps
module fls_field_limit_switch #(
	parameter int PULSE_CYC = fls_pkg::INT_PULSE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cfgWrEn,
	input wire logic [3:0] cfgAddr,
	input wire logic [7:0] cfgWrData,
	output logic [7:0] cfgRdData,
	input wire logic convDone,
	input wire logic signed [fls_pkg::DATA_W-1:0] xResult,
	input wire logic signed [fls_pkg::DATA_W-1:0] yResult,
	input wire logic signed [fls_pkg::DATA_W-1:0] zResult,
	input wire logic [7:0] magnitudeIn,
	input wire logic [fls_pkg::ANG_W-1:0] angleIn,
	input wire logic [2:0] chanEn,
	input wire logic [1:0] opMode,
	input wire logic intPinIn,
	output logic intPinOut,
	output logic intPinOe,
	output logic convTrigger,
	output logic switchOn
);
	import fls_pkg::*;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [7:0] limitWordOne_ff;
	logic [7:0] limitWordTwo_ff;
	logic [7:0] limitWordThree_ff;
	logic [7:0] xUpperLimit_ff;
	logic [7:0] yUpperLimit_ff;
	logic [7:0] zUpperLimit_ff;
	logic [7:0] limitCtrl_ff;
	logic [2:0] switchHysteresis_ff;

	fls_sel_e thresholdSelect;
	logic limitRegionDirection;
	logic [2:0] intPinMode;
	logic switchMode;
	logic omniMode;

	assign thresholdSelect = fls_sel_e'(limitCtrl_ff[CTRL_SEL_LSB +: 2]);
	assign limitRegionDirection = limitCtrl_ff[CTRL_DIR_BIT];
	assign intPinMode = limitCtrl_ff[CTRL_MODE_LSB +: 3];
	assign switchMode = (intPinMode == MODE_UNIPOLAR) || (intPinMode == MODE_OMNIPOLAR);
	assign omniMode = (intPinMode == MODE_OMNIPOLAR);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			limitWordOne_ff <= RST_LIMIT;
			limitWordTwo_ff <= RST_LIMIT;
			limitWordThree_ff <= RST_LIMIT;
			xUpperLimit_ff <= RST_LIMIT;
			yUpperLimit_ff <= RST_LIMIT;
			zUpperLimit_ff <= RST_LIMIT;
			limitCtrl_ff <= RST_CTRL;
			switchHysteresis_ff <= RST_HYST;
		end else if (cfgWrEn) begin
			case (cfgAddr)
				ADDR_LIMIT_WORD_ONE: limitWordOne_ff <= cfgWrData;
				ADDR_LIMIT_WORD_TWO: limitWordTwo_ff <= cfgWrData;
				ADDR_LIMIT_WORD_THREE: limitWordThree_ff <= cfgWrData;
				ADDR_X_UPPER_LIMIT: xUpperLimit_ff <= cfgWrData;
				ADDR_Y_UPPER_LIMIT: yUpperLimit_ff <= cfgWrData;
				ADDR_Z_UPPER_LIMIT: zUpperLimit_ff <= cfgWrData;
				ADDR_LIMIT_CTRL: limitCtrl_ff <= cfgWrData;
				ADDR_SWITCH_HYST: switchHysteresis_ff <= cfgWrData[HYST_LSB +: 3];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// conversion capture and evaluation stage
	// ----------------------------------------
	logic signed [DATA_W-1:0] res_ff [3];
	logic [7:0] magnitudeResult_ff;
	logic [9:0] angleCorr_ff;
	fls_stage_e stage_ff;
	logic [9:0] angleSum;

	// offset added to the computed angle, wrapped to one turn
	assign angleSum = 10'(angleIn) + 10'(limitWordThree_ff);

	// opMode deliberately not used: checks run the same in every mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			res_ff[0] <= '0;
			res_ff[1] <= '0;
			res_ff[2] <= '0;
			magnitudeResult_ff <= RST_RESULT;
			angleCorr_ff <= '0;
		end else if (convDone) begin
			res_ff[0] <= xResult;
			res_ff[1] <= yResult;
			res_ff[2] <= zResult;
			magnitudeResult_ff <= magnitudeIn;
			angleCorr_ff <= (thresholdSelect == SEL_ANGLE) ? fls_wrap360(angleSum) : 10'(angleIn);
		end
	end

	// one evaluation cycle after each capture
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage_ff <= ST_IDLE;
		end else begin
			case (stage_ff)
				ST_IDLE: stage_ff <= convDone ? ST_EVAL : ST_IDLE;
				ST_EVAL: stage_ff <= convDone ? ST_EVAL : ST_IDLE;
				default: stage_ff <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// comparators: three axes and magnitude
	// ----------------------------------------
	fls_cmp_if cmpBus [4] ();
	logic [3:0] oorVec;
	logic [3:0] opVec;
	logic [3:0] hiVec;
	logic [3:0] relVec;
	logic [7:0] lowWord [3];
	logic [7:0] highWord [3];

	assign lowWord[0] = limitWordOne_ff;
	assign lowWord[1] = limitWordTwo_ff;
	assign lowWord[2] = limitWordThree_ff;
	assign highWord[0] = xUpperLimit_ff;
	assign highWord[1] = yUpperLimit_ff;
	assign highWord[2] = zUpperLimit_ff;

	for (genvar i = 0; i < 3; i++) begin : g_axis
		// 128 counts of a limit equal full scale of the result
		assign cmpBus[i].value = {res_ff[i][DATA_W-1], res_ff[i]};
		assign cmpBus[i].lo = {lowWord[i][7], lowWord[i], 4'h0};
		assign cmpBus[i].hi = {highWord[i][7], highWord[i], 4'h0};
		assign cmpBus[i].hyst = {6'h00, switchHysteresis_ff, 4'h0};
		assign cmpBus[i].loEn = (lowWord[i] != 8'h00);
		assign cmpBus[i].hiEn = (highWord[i] != 8'h00);
		assign cmpBus[i].dir = limitRegionDirection;
		assign cmpBus[i].omni = omniMode;
	end

	// magnitude limits are plain unsigned bytes
	assign cmpBus[3].value = {5'h00, magnitudeResult_ff};
	assign cmpBus[3].lo = {5'h00, limitWordOne_ff};
	assign cmpBus[3].hi = {5'h00, limitWordTwo_ff};
	assign cmpBus[3].hyst = '0;
	assign cmpBus[3].loEn = (limitWordOne_ff != 8'h00);
	assign cmpBus[3].hiEn = (limitWordTwo_ff != 8'h00);
	assign cmpBus[3].dir = limitRegionDirection;
	assign cmpBus[3].omni = 1'b0;

	for (genvar i = 0; i < 4; i++) begin : g_cmp
		fls_limit_cmp u_cmp (
			.c(cmpBus[i])
		);
		assign oorVec[i] = cmpBus[i].oor;
		assign opVec[i] = cmpBus[i].opHit;
		assign hiVec[i] = cmpBus[i].hiHit;
		assign relVec[i] = cmpBus[i].rpBelow;
	end

	// ----------------------------------------
	// angle window
	// ----------------------------------------
	logic [9:0] refDeg;
	logic [9:0] angDiff;
	logic [9:0] angDist;
	logic angleInBand;
	logic angleOor;

	always_comb begin
		refDeg = fls_wrap360(10'({limitWordOne_ff, 1'b0}));
		angDiff = (angleCorr_ff >= refDeg) ? angleCorr_ff - refDeg : refDeg - angleCorr_ff;
		angDist = (angDiff > (ANGLE_FULL_DEG >> 1)) ? ANGLE_FULL_DEG - angDiff : angDiff;
		angleInBand = (angDist <= 10'(limitWordTwo_ff));
		angleOor = (limitWordTwo_ff != 8'h00) && (limitRegionDirection ? angleInBand : !angleInBand);
	end

	// ----------------------------------------
	// region decision per selector
	// ----------------------------------------
	logic outOfRange;

	always_comb begin
		case (thresholdSelect)
			SEL_ANGLE: outOfRange = angleOor;
			SEL_AXIS: outOfRange = |(oorVec[2:0] & chanEn);
			SEL_MAG: outOfRange = oorVec[3];
			default: outOfRange = 1'b0;
		endcase
	end

	// ----------------------------------------
	// switch state
	// ----------------------------------------
	logic switchOn_ff;
	logic nxt_switchOn;
	logic anyOperate;
	logic allReleased;

	assign anyOperate = |(opVec[2:0] & chanEn);
	assign allReleased = &(relVec[2:0] | ~chanEn);

	always_comb begin
		nxt_switchOn = switchOn_ff;
		if (!switchMode) begin
			nxt_switchOn = 1'b0;
		end else if (stage_ff == ST_EVAL) begin
			case (thresholdSelect)
				SEL_AXIS: begin
					if (!switchOn_ff && anyOperate) begin
						nxt_switchOn = 1'b1;
					end else if (switchOn_ff && allReleased) begin
						nxt_switchOn = 1'b0;
					end
				end
				SEL_MAG: begin
					// magnitude is never negative, no omnipolar form
					if (omniMode) begin
						nxt_switchOn = 1'b0;
					end else if (!switchOn_ff && hiVec[3]) begin
						nxt_switchOn = 1'b1;
					end else if (switchOn_ff && cmpBus[3].loEn && relVec[3]) begin
						nxt_switchOn = 1'b0;
					end
				end
				default: nxt_switchOn = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			switchOn_ff <= 1'b0;
		end else begin
			switchOn_ff <= nxt_switchOn;
		end
	end

	// ----------------------------------------
	// interrupt pulse
	// ----------------------------------------
	logic [PULSE_CNT_W-1:0] pulseCnt_ff;
	logic pulseHit;

	assign pulseHit = (stage_ff == ST_EVAL) && outOfRange && !switchMode && (intPinMode != MODE_OFF);

	// restarts on every out-of-range conversion, not only the first
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pulseCnt_ff <= '0;
		end else if (pulseHit) begin
			pulseCnt_ff <= PULSE_CNT_W'(PULSE_CYC);
		end else if (switchMode) begin
			pulseCnt_ff <= '0;
		end else if (pulseCnt_ff != '0) begin
			pulseCnt_ff <= pulseCnt_ff - 1'b1;
		end
	end

	// ----------------------------------------
	// pin drive and conversion trigger
	// ----------------------------------------
	logic intPinOut_ff;
	logic intPinOe_ff;
	logic pinPrev_ff;
	logic convTrigger_ff;
	logic nxt_pinDrive;

	// open drain: low level, enable low while pulling
	assign nxt_pinDrive = switchMode ? nxt_switchOn : (pulseHit || (pulseCnt_ff > 1));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			intPinOut_ff <= 1'b0;
			intPinOe_ff <= 1'b1;
		end else begin
			intPinOut_ff <= 1'b0;
			intPinOe_ff <= !nxt_pinDrive;
		end
	end

	// falling edge from the host starts a conversion
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pinPrev_ff <= 1'b1;
			convTrigger_ff <= 1'b0;
		end else begin
			pinPrev_ff <= intPinIn;
			convTrigger_ff <= pinPrev_ff && !intPinIn && intPinOe_ff && !switchMode;
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	logic [7:0] cfgRdData_ff;
	logic [7:0] statusWord;

	assign statusWord = {switchOn_ff, 2'b00, angleOor, oorVec[3], oorVec[2:0] & chanEn};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfgRdData_ff <= 8'h00;
		end else begin
			case (cfgAddr)
				ADDR_LIMIT_WORD_ONE: cfgRdData_ff <= limitWordOne_ff;
				ADDR_LIMIT_WORD_TWO: cfgRdData_ff <= limitWordTwo_ff;
				ADDR_LIMIT_WORD_THREE: cfgRdData_ff <= limitWordThree_ff;
				ADDR_X_UPPER_LIMIT: cfgRdData_ff <= xUpperLimit_ff;
				ADDR_Y_UPPER_LIMIT: cfgRdData_ff <= yUpperLimit_ff;
				ADDR_Z_UPPER_LIMIT: cfgRdData_ff <= zUpperLimit_ff;
				ADDR_LIMIT_CTRL: cfgRdData_ff <= limitCtrl_ff;
				ADDR_SWITCH_HYST: cfgRdData_ff <= {5'h00, switchHysteresis_ff};
				ADDR_MAGNITUDE_RESULT: cfgRdData_ff <= magnitudeResult_ff;
				ADDR_LIMIT_STATUS: cfgRdData_ff <= statusWord;
				default: cfgRdData_ff <= 8'h00;
			endcase
		end
	end

	assign cfgRdData = cfgRdData_ff;
	assign intPinOut = intPinOut_ff;
	assign intPinOe = intPinOe_ff;
	assign convTrigger = convTrigger_ff;
	assign switchOn = switchOn_ff;

endmodule

// ===== tb/fls_field_limit_switch_checker.sv
// assertions on the ports of the field limit switch block
`timescale 1ns/1ps
module fls_field_limit_switch_checker #(
	parameter int PULSE_CYC = 100
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cfgWrEn,
	input wire logic [3:0] cfgAddr,
	input wire logic [7:0] cfgWrData,
	input wire logic [7:0] cfgRdData,
	input wire logic convDone,
	input wire logic intPinIn,
	input wire logic intPinOe,
	input wire logic convTrigger,
	input wire logic switchOn
);
	import fls_pkg::*;
	logic [2:0] modeFf;
	logic [15:0] lowCnt;
	logic swMode;
	logic pulseMode;
	assign swMode = modeFf == MODE_UNIPOLAR || modeFf == MODE_OMNIPOLAR;
	assign pulseMode = !swMode && modeFf != MODE_OFF;
	// ----
	// helper state
	// ----
	always_ff @(posedge clk) begin
		if (!resetn)
			modeFf <= MODE_OFF;
		else if (cfgWrEn && cfgAddr == ADDR_LIMIT_CTRL)
			modeFf <= cfgWrData[CTRL_MODE_LSB+:3];
	end
	// cycles the pin has been held low
	always_ff @(posedge clk) begin
		if (!resetn || intPinOe)
			lowCnt <= 16'h0;
		else
			lowCnt <= lowCnt + 16'h1;
	end
	// ----
	// properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_oe_after_conv: assert property ($fell(intPinOe) |-> $past(convDone, 2))
		else $error("pin pulled low without a conversion two cycles before");
	a_switch_after_conv: assert property ($changed(switchOn) |-> $past(convDone, 2))
		else $error("switch state moved without a conversion");
	a_switch_drives_pin: assert property (swMode && switchOn |-> !intPinOe)
		else $error("switch on but pin released");
	a_no_pin_trigger: assert property (swMode && $past(swMode) |-> !convTrigger)
		else $error("conversion trigger in switch mode");
	a_trigger_single: assert property (convTrigger |=> !convTrigger)
		else $error("trigger longer than one cycle");
	a_trigger_cause: assert property (convTrigger |-> !$past(intPinIn) || !$past(intPinIn, 2))
		else $error("trigger without low pin");
	a_pulse_min_len: assert property (pulseMode && $rose(intPinOe) |-> lowCnt >= PULSE_CYC)
		else $error("interrupt pulse too short");
	a_quiet_when_off: assert property ($fell(intPinOe) |-> modeFf != MODE_OFF || $past(modeFf) != MODE_OFF)
		else $error("interrupt with pin mode off");
	a_word_readback: assert property (cfgWrEn && cfgAddr < ADDR_LIMIT_CTRL ##1 !cfgWrEn && $stable(cfgAddr)
		|=> cfgRdData == $past(cfgWrData, 2))
		else $error("limit word reads back wrong");
endmodule
bind fls_field_limit_switch fls_field_limit_switch_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk(clk),
	.resetn(resetn), .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
	.convDone(convDone), .intPinIn(intPinIn), .intPinOe(intPinOe), .convTrigger(convTrigger), .switchOn(switchOn));

// ===== tb/fls_host_model.sv
// host side of the interrupt wire: pull-up, host pull-down, interrupt count
`timescale 1ns/1ps
module fls_host_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic intPinOut,
	input wire logic intPinOe,
	input wire logic hostPull,
	output logic intPinIn,
	output int irqCnt
);
	logic oeFf;
	// open-drain wire with pull-up, either side may pull low
	assign intPinIn = (intPinOe || intPinOut) && !hostPull;
	always @(posedge clk) begin
		if (!resetn)
			irqCnt <= 0;
		else if (oeFf && !intPinOe)
			irqCnt <= irqCnt + 1;
		oeFf <= intPinOe;
	end
endmodule

// ===== tb/field_limit_switch_logic_test.sv
// self-checking bench of the field limit switch block
`timescale 1ns/1ps
module field_limit_switch_logic_test;
	import fls_pkg::*;
	localparam int PC = 4;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cfgWrEn = 1'b0;
	logic convDone = 1'b0;
	logic hostPull = 1'b0;
	logic [3:0] cfgAddr = 4'h0;
	logic [7:0] cfgWrData = 8'h00;
	logic [7:0] magnitudeIn = 8'h00;
	logic [ANG_W-1:0] angleIn = 9'h000;
	logic signed [DATA_W-1:0] xResult = 12'h000;
	logic signed [DATA_W-1:0] yResult = 12'h000;
	logic signed [DATA_W-1:0] zResult = 12'h000;
	logic [2:0] chanEn = 3'h7;
	logic [1:0] opMode = 2'h0;
	logic [7:0] cfgRdData;
	logic intPinIn, intPinOut, intPinOe, convTrigger, switchOn;
	int irqCnt;
	int n_fail = 0;
	int n_tests = 0;
	int seed = 48;
	int expIrq = 0;
	int sw = 0;
	int rg[8];

	always #50 clk = !clk;

	fls_field_limit_switch #(.PULSE_CYC(PC)) dut (.clk(clk), .resetn(resetn), .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr),
		.cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .convDone(convDone), .xResult(xResult), .yResult(yResult),
		.zResult(zResult), .magnitudeIn(magnitudeIn), .angleIn(angleIn), .chanEn(chanEn), .opMode(opMode),
		.intPinIn(intPinIn), .intPinOut(intPinOut), .intPinOe(intPinOe), .convTrigger(convTrigger),
		.switchOn(switchOn));
	fls_host_model host (.clk(clk), .resetn(resetn), .intPinOut(intPinOut), .intPinOe(intPinOe),
		.hostPull(hostPull), .intPinIn(intPinIn), .irqCnt(irqCnt));

	// ----
	// reference model
	// ----
	function automatic int sx(input int w);
		return (w > 127 ? w - 256 : w) * 16;
	endfunction
	function automatic bit lim(input int v, input int lo, input int hi, input bit le, input bit he);
		if (!le && !he)
			return 0;
		if (rg[6][2] == 0)
			return (he && v > hi) || (le && v < lo);
		return (!le || v >= lo) && (!he || v <= hi);
	endfunction
	function automatic bit oor(input int x[3], input int m, input int an);
		int a, r, d;
		bit o;
		o = 0;
		case (rg[6] & 3)
			1: begin
				a = (an + rg[2]) % 360;
				r = (rg[0] * 2) % 360;
				d = a > r ? a - r : r - a;
				if (d > 180)
					d = 360 - d;
				o = rg[1] != 0 && ((d <= rg[1]) == rg[6][2]);
			end
			2: for (int i = 0; i < 3; i++)
				if (chanEn[i])
					o |= lim(x[i], sx(rg[i]), sx(rg[3 + i]), rg[i] != 0, rg[3 + i] != 0);
			3: o = lim(m, rg[0], rg[1], rg[0] != 0, rg[1] != 0);
			default: o = 0;
		endcase
		return o;
	endfunction
	task automatic swUpd(input int x[3]);
		bit on, off;
		int v, t;
		on = 0;
		off = 1;
		for (int i = 0; i < 3; i++) begin
			t = sx(rg[i]);
			v = x[i];
			if (rg[6][5:3] == 6) begin
				v = v < 0 ? -v : v;
				t = t < 0 ? -t : t;
			end
			on |= v >= t;
			off &= v < t - rg[7] * 16;
		end
		sw = on ? 1 : off ? 0 : sw;
	endtask

	// ----
	// drivers and checks
	// ----
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic doReset();
		@(negedge clk);
		resetn = 1'b0;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		rg = '{default: 0};
		sw = 0;
	endtask
	task automatic wr(input int a, input int d);
		@(negedge clk);
		cfgWrEn = 1'b1;
		cfgAddr = 4'(a);
		cfgWrData = 8'(d);
		@(negedge clk);
		cfgWrEn = 1'b0;
		if (a < 8)
			rg[a] = d & 255;
	endtask
	task automatic rd(input int a, output logic [7:0] v);
		@(negedge clk);
		cfgAddr = 4'(a);
		@(negedge clk);
		v = cfgRdData;
	endtask
	task automatic conv();
		int x[3];
		int m, an, md;
		logic [7:0] v;
		bit o, s;
		for (int i = 0; i < 3; i++)
			x[i] = ($random(seed) % 128) * 16 + 8;
		m = ($random(seed) & 255) | 1;
		an = (($random(seed) & 255) % 180) * 2 + 1;
		@(negedge clk);
		xResult = 12'(x[0]);
		yResult = 12'(x[1]);
		zResult = 12'(x[2]);
		magnitudeIn = 8'(m);
		angleIn = 9'(an);
		opMode = 2'($random(seed));
		convDone = 1'b1;
		@(negedge clk);
		convDone = 1'b0;
		repeat (2) @(negedge clk);
		o = oor(x, m, an);
		md = rg[6][5:3];
		if (md == 5 || md == 6) begin
			swUpd(x);
			chk("switch state", 16'(switchOn), 16'(sw));
			chk("pin level", 16'(intPinOe), 16'(!sw));
			chk("pin wire", 16'(intPinIn), 16'(!sw));
		end else begin
			expIrq += (md != 0 && o);
			chk("pin pulse", 16'(intPinOe), 16'(!(md != 0 && o)));
			chk("pin wire low", 16'(intPinIn), 16'(!(md != 0 && o)));
		end
		repeat (PC + 1) @(negedge clk);
		if ((rg[6] & 3) == 3) begin
			rd(ADDR_MAGNITUDE_RESULT, v);
			chk("magnitude result", 16'(v), 16'(m));
		end
		rd(ADDR_LIMIT_STATUS, v);
		chk("status switch", 16'(v[STAT_SWITCH_BIT]), 16'(sw));
		s = (rg[6] & 3) == 1 ? v[STAT_ANGLE_BIT] : (rg[6] & 3) == 3 ? v[STAT_MAG_BIT] : |v[2:0];
		if (md != 6)
			chk("status range", 16'(s), 16'(o));
	endtask
	task automatic trig();
		bit seen;
		int md;
		md = rg[6][5:3];
		seen = 0;
		@(negedge clk);
		hostPull = 1'b1;
		repeat (3) begin
			@(negedge clk);
			seen |= convTrigger;
		end
		hostPull = 1'b0;
		chk("trigger", 16'(seen), 16'(!(md == 5 || md == 6)));
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----
	// sequence
	// ----
	initial begin
		logic [7:0] v;
		int w;
		doReset();
		for (int a = 0; a < 16; a++)
			wr(a, $random(seed));
		for (int a = 0; a < 16; a++) begin
			if (a == 8 || a == 9)
				continue;
			rd(a, v);
			w = a == 7 ? 7 : a == 6 ? 63 : 255;
			chk("register", 16'(v & w), 16'(a < 8 ? rg[a] & w : 0));
		end
		$display("test registers done");
		for (int k = 0; k < 12; k++) begin
			for (int a = 0; a < 6; a++)
				wr(a, $random(seed) & 254);
			if (k % 4 == 0)
				wr(0, 0);
			if (k % 3 == 0)
				wr(1, (($random(seed) & 127) % 91) * 2);
			wr(6, (k % 3 + 1) + (k / 3 % 2) * 4 + (k < 10 ? 8 : 0));
			chanEn = 3'($random(seed));
			repeat (10) conv();
			trig();
			$display("test limits %0d done", k);
		end
		chk("interrupt count", 16'(irqCnt), 16'(expIrq));
		for (int k = 0; k < 2; k++) begin
			doReset();
			for (int a = 0; a < 3; a++)
				wr(a, ($random(seed) & 254) | 2);
			wr(7, $random(seed) & 7);
			wr(6, k ? 50 : 42);
			chanEn = 3'h7;
			repeat (30) conv();
			trig();
			$display("test switch %0d done", k);
		end
		results();
	end

	initial begin
		#2000000;
		n_fail++;
		results();
	end
endmodule
